// >>> smoc_pkg.sv
// smoc_pkg: offsets, field positions, reset values and mode codes
// assumes one core clock domain and a byte-wide register interface
package smoc_pkg;
	localparam logic [7:0] CONFIG_TWO_ADDR     = 8'h16;
	localparam logic [7:0] RATE_DEC_ADDR       = 8'h17;
	localparam logic [7:0] REST_IDLE_HI_ADDR   = 8'h18;
	localparam logic [7:0] REST_IDLE_LO_ADDR   = 8'h19;
	localparam logic [7:0] CONFIG_TWO_RESET    = 8'h00;
	localparam logic [7:0] RATE_DEC_RESET      = 8'h00;
	localparam logic [7:0] IDLE_RESET          = 8'h00;
	localparam int         REST_PM_HI          = 5;
	localparam int         REST_PM_LO          = 4;
	localparam int         BYTE_ORDER_BIT      = 3;
	localparam int         TEMP_INC_BIT        = 1;
	localparam int         FAST_READ_BIT       = 0;
	localparam logic [1:0] PM_LOW_POWER        = 2'h0;
	localparam logic [1:0] PM_HIGH_PERF        = 2'h1;
	typedef enum logic [1:0] {
		SMOC_LOW_POWER,
		SMOC_HIGH_PERF,
		SMOC_FLEXIBLE
	} smoc_mode_t;
endpackage

// >>> smoc_config.sv
// smoc_config: sleep power mode and output format configuration bank
// assumes a same-clock byte register port driven by the serial interface
`timescale 1ns/1ps

module smoc_config (
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic        REG_WR,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	output logic      [7:0]  REG_RDATA,
	input  wire logic [11:0] SAMPLE,
	input  wire logic        ORDERED_FIELD,
	input  wire logic        FIELD_HI_ADDR,
	input  wire logic        BURST_AXIS_DATA,
	output logic      [7:0]  DATA_BYTE,
	output logic             SKIP_HI_ADDR,
	output logic             TEMP_IN_RANGE,
	output logic      [1:0]  REST_MODE,
	output logic      [3:0]  REST_RATE_CODE,
	output logic      [3:0]  REST_DEC_CODE,
	output logic             REST_CODE_IS_DEC,
	output logic      [11:0] REST_IDLE_TIME,
	output logic             FAST_READ
);
	typedef struct packed {
		logic [7:0]           cfg;
		logic [7:0]           rate;
		logic [3:0]           idle_hi;
		logic [7:0]           idle_lo;
		logic [7:0]           rdata;
		logic [7:0]           dbyte;
		smoc_pkg::smoc_mode_t mode;
		logic [3:0]           rate_code;
		logic [3:0]           dec_code;
		logic                 is_dec;
	} smoc_state_t;

	smoc_state_t st_q;
	smoc_state_t st_d;

	logic       wr_cfg;
	logic       wr_rate;
	logic       wr_idle_hi;
	logic       wr_idle_lo;
	logic       order_be;
	logic       fast_rd;
	logic [1:0] pm_next;
	logic [3:0] nib_next;

	// write strobes per register
	assign wr_cfg     = REG_WR && (REG_ADDR == smoc_pkg::CONFIG_TWO_ADDR);
	assign wr_rate    = REG_WR && (REG_ADDR == smoc_pkg::RATE_DEC_ADDR);
	assign wr_idle_hi = REG_WR && (REG_ADDR == smoc_pkg::REST_IDLE_HI_ADDR);
	assign wr_idle_lo = REG_WR && (REG_ADDR == smoc_pkg::REST_IDLE_LO_ADDR);

	// format controls from the stored byte
	assign order_be = st_q.cfg[smoc_pkg::BYTE_ORDER_BIT];
	assign fast_rd  = st_q.cfg[smoc_pkg::FAST_READ_BIT];

	always_comb begin
		st_d = st_q;
		// register writes
		if (wr_cfg) begin
			st_d.cfg = REG_WDATA;
		end
		if (wr_rate) begin
			st_d.rate = REG_WDATA;
		end
		if (wr_idle_hi) begin
			st_d.idle_hi = REG_WDATA[3:0];
		end
		if (wr_idle_lo) begin
			st_d.idle_lo = REG_WDATA;
		end
		// sleep mode decode from the values being stored
		pm_next  = st_d.cfg[smoc_pkg::REST_PM_HI:smoc_pkg::REST_PM_LO];
		nib_next = st_d.rate[3:0];
		if (pm_next[1]) begin
			st_d.mode      = smoc_pkg::SMOC_FLEXIBLE;
			st_d.is_dec    = 1'b1;
			st_d.rate_code = 4'h0;
			st_d.dec_code  = nib_next;
		end else if (pm_next == smoc_pkg::PM_HIGH_PERF) begin
			st_d.mode      = smoc_pkg::SMOC_HIGH_PERF;
			st_d.is_dec    = 1'b0;
			st_d.rate_code = nib_next;
			st_d.dec_code  = 4'h0;
		end else begin
			st_d.mode      = smoc_pkg::SMOC_LOW_POWER;
			st_d.is_dec    = 1'b0;
			st_d.rate_code = nib_next;
			st_d.dec_code  = 4'h0;
		end
		// register readback
		if (REG_ADDR == smoc_pkg::CONFIG_TWO_ADDR) begin
			st_d.rdata = st_q.cfg;
		end else if (REG_ADDR == smoc_pkg::RATE_DEC_ADDR) begin
			st_d.rdata = st_q.rate;
		end else if (REG_ADDR == smoc_pkg::REST_IDLE_HI_ADDR) begin
			st_d.rdata = {4'h0, st_q.idle_hi};
		end else if (REG_ADDR == smoc_pkg::REST_IDLE_LO_ADDR) begin
			st_d.rdata = st_q.idle_lo;
		end else begin
			st_d.rdata = 8'h00;
		end
		// output data byte formatting
		if (ORDERED_FIELD && fast_rd) begin
			if (FIELD_HI_ADDR) begin
				st_d.dbyte = 8'h00;
			end else begin
				st_d.dbyte = SAMPLE[11:4];
			end
		end else if (ORDERED_FIELD && order_be) begin
			if (FIELD_HI_ADDR) begin
				st_d.dbyte = {SAMPLE[3:0], 4'h0};
			end else begin
				st_d.dbyte = SAMPLE[11:4];
			end
		end else begin
			if (FIELD_HI_ADDR) begin
				st_d.dbyte = {4'h0, SAMPLE[11:8]};
			end else begin
				st_d.dbyte = SAMPLE[7:0];
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			st_q.cfg       <= smoc_pkg::CONFIG_TWO_RESET;
			st_q.rate      <= smoc_pkg::RATE_DEC_RESET;
			st_q.idle_hi   <= smoc_pkg::IDLE_RESET[3:0];
			st_q.idle_lo   <= smoc_pkg::IDLE_RESET;
			st_q.rdata     <= 8'h00;
			st_q.dbyte     <= 8'h00;
			st_q.mode      <= smoc_pkg::SMOC_LOW_POWER;
			st_q.rate_code <= smoc_pkg::RATE_DEC_RESET[3:0];
			st_q.dec_code  <= 4'h0;
			st_q.is_dec    <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs
	assign REG_RDATA        = st_q.rdata;
	assign DATA_BYTE        = st_q.dbyte;
	assign SKIP_HI_ADDR     = fast_rd && BURST_AXIS_DATA;
	assign TEMP_IN_RANGE    = st_q.cfg[smoc_pkg::TEMP_INC_BIT];
	assign REST_MODE        = st_q.mode;
	assign REST_RATE_CODE   = st_q.rate_code;
	assign REST_DEC_CODE    = st_q.dec_code;
	assign REST_CODE_IS_DEC = st_q.is_dec;
	assign REST_IDLE_TIME   = {st_q.idle_hi, st_q.idle_lo};
	assign FAST_READ        = fast_rd;

	// checks
	property p_low_power_mode;
		@(posedge CORE_CLK) disable iff (RST)
		wr_cfg && (REG_WDATA[smoc_pkg::REST_PM_HI:smoc_pkg::REST_PM_LO] == smoc_pkg::PM_LOW_POWER)
		|=> (REST_MODE == smoc_pkg::SMOC_LOW_POWER) && !REST_CODE_IS_DEC
			&& (REST_RATE_CODE == st_q.rate[3:0]);
	endproperty
	a_low_power_mode: assert property (p_low_power_mode)
		else $error("low power mode not selected");

	property p_high_perf_mode;
		@(posedge CORE_CLK) disable iff (RST)
		wr_cfg && (REG_WDATA[smoc_pkg::REST_PM_HI:smoc_pkg::REST_PM_LO] == smoc_pkg::PM_HIGH_PERF)
		|=> (REST_MODE == smoc_pkg::SMOC_HIGH_PERF) && !REST_CODE_IS_DEC
			&& (REST_RATE_CODE == st_q.rate[3:0]);
	endproperty
	a_high_perf_mode: assert property (p_high_perf_mode)
		else $error("high performance mode not selected");

	property p_flexible_mode;
		@(posedge CORE_CLK) disable iff (RST)
		wr_cfg && REG_WDATA[smoc_pkg::REST_PM_HI]
		|=> (REST_MODE == smoc_pkg::SMOC_FLEXIBLE) && REST_CODE_IS_DEC
			&& (REST_DEC_CODE == st_q.rate[3:0]);
	endproperty
	a_flexible_mode: assert property (p_flexible_mode)
		else $error("flexible mode not selected");

	property p_idle_time;
		@(posedge CORE_CLK) disable iff (RST)
		wr_idle_lo |=> REST_IDLE_TIME[7:0] == $past(REG_WDATA);
	endproperty
	a_idle_time: assert property (p_idle_time)
		else $error("idle time low byte not stored");

	property p_temp_include;
		@(posedge CORE_CLK) disable iff (RST)
		wr_cfg |=> TEMP_IN_RANGE == $past(REG_WDATA[smoc_pkg::TEMP_INC_BIT]);
	endproperty
	a_temp_include: assert property (p_temp_include)
		else $error("temperature include bit not stored");

	property p_fast_msb;
		@(posedge CORE_CLK) disable iff (RST)
		FAST_READ && ORDERED_FIELD && !FIELD_HI_ADDR |=> DATA_BYTE == $past(SAMPLE[11:4]);
	endproperty
	a_fast_msb: assert property (p_fast_msb)
		else $error("fast read byte is not the sample top byte");

	property p_big_endian_hi;
		@(posedge CORE_CLK) disable iff (RST)
		!FAST_READ && order_be && ORDERED_FIELD && FIELD_HI_ADDR
		|=> DATA_BYTE == {$past(SAMPLE[3:0]), 4'h0};
	endproperty
	a_big_endian_hi: assert property (p_big_endian_hi)
		else $error("big endian upper byte not left justified");

	property p_fixed_little_hi;
		@(posedge CORE_CLK) disable iff (RST)
		!ORDERED_FIELD && FIELD_HI_ADDR |=> DATA_BYTE == {4'h0, $past(SAMPLE[11:8])};
	endproperty
	a_fixed_little_hi: assert property (p_fixed_little_hi)
		else $error("fixed field upper byte not right justified");

endmodule // smoc_config

// >>> smoc_host.sv
// smoc_host: register-writing host beside the bank
`timescale 1ns/1ps
// assumes the bank samples its write strobe on the rising edge after the one that drives it
module smoc_host #(
	parameter bit BOOT_HIGH_MOTION = 1'b0
) (
	input  wire logic       CORE_CLK,
	output logic            WR = 1'b0,
	output logic      [7:0] A  = 8'h00,
	output logic      [7:0] D  = 8'h00
);
	task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
		logic [7:0] v;
		v = dt;
		if (BOOT_HIGH_MOTION && (ad == smoc_pkg::CONFIG_TWO_ADDR)) begin
			v[5:4] = smoc_pkg::PM_LOW_POWER;
		end
		@(posedge CORE_CLK) {WR, A, D} <= {1'b1, ad, v};
		@(posedge CORE_CLK) {WR, A, D} <= {1'b0, ~ad, ~v};
	endtask
	task automatic rd_sel(input logic [7:0] ad);
		@(posedge CORE_CLK) {WR, A} <= {1'b0, ad};
		@(posedge CORE_CLK);
	endtask
endmodule // smoc_host

// >>> testbench.sv
// testbench: mode and read-format checks through register writes
`timescale 1ns/1ps
module testbench;
	logic c = 0, r = 1, w, ti, fr, cd, sk, of = 1, ha = 0, ba = 1;
	logic [7:0] a, d, db, rd; logic [1:0] m; logic [3:0] rc, dc; logic [11:0] it;
	logic [11:0] smp = 12'hABC; int errors, compares, n;
	always #5 c = ~c;
	smoc_host i_smoc_host (.CORE_CLK(c), .WR(w), .A(a), .D(d));
	smoc_config i_smoc_config (.CORE_CLK(c), .RST(r), .REG_WR(w), .REG_ADDR(a), .REG_WDATA(d),
		.REG_RDATA(rd), .SAMPLE(smp), .ORDERED_FIELD(of), .FIELD_HI_ADDR(ha),
		.BURST_AXIS_DATA(ba), .DATA_BYTE(db), .SKIP_HI_ADDR(sk), .TEMP_IN_RANGE(ti),
		.REST_MODE(m), .REST_RATE_CODE(rc), .REST_DEC_CODE(dc), .REST_CODE_IS_DEC(cd),
		.REST_IDLE_TIME(it), .FAST_READ(fr));
	task automatic settle;
		repeat (2) @(posedge c);
		#1;
	endtask
	task automatic sel(logic o, h);
		@(posedge c) begin of <= o; ha <= h; end
		settle;
	endtask
	task automatic chk(string s, logic [11:0] e, g);
		compares++;
		if (g !== e) begin errors++; $display("FAIL %s exp %h got %h", s, e, g); end
	endtask
	task automatic tally_and_finish;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge c) if (++n > 999) begin errors++; tally_and_finish; end
	task automatic t_fast;
		chk("temp_rst", 8'h00, ti);
		i_smoc_host.wr(smoc_pkg::CONFIG_TWO_ADDR, 8'h13); repeat (2) @(posedge c); #1;
		chk("mode", smoc_pkg::SMOC_HIGH_PERF, m);
		chk("temp_fast", 8'h03, {ti, fr});
		chk("msb", 8'hAB, db);
		chk("skip", 1, sk);
		sel(1'b1, 1'b0);
		i_smoc_host.wr(smoc_pkg::CONFIG_TWO_ADDR, 8'h19); settle;
		chk("msb_be", 8'hAB, db);
	endtask
	task automatic t_flex;
		i_smoc_host.wr(smoc_pkg::CONFIG_TWO_ADDR, 8'h20); settle;
		i_smoc_host.wr(smoc_pkg::RATE_DEC_ADDR, 8'h5C); settle;
		chk("dec", 8'h01, cd);
		chk("dec_code", 4'hC, dc);
		chk("mode_flex", smoc_pkg::SMOC_FLEXIBLE, m);
		chk("noskip", 0, sk);
		chk("le_lo", 8'hBC, db);
		sel(1'b1, 1'b1);
		chk("le_hi", 8'h0A, db);
	endtask
	task automatic t_order;
		i_smoc_host.wr(smoc_pkg::CONFIG_TWO_ADDR, 8'h08); settle;
		chk("mode_lp", smoc_pkg::SMOC_LOW_POWER, m);
		chk("rate_code", 4'hC, rc);
		chk("be_hi", 8'hC0, db);
		sel(1'b1, 1'b0);
		chk("be_lo", 8'hAB, db);
		sel(1'b0, 1'b1);
		chk("fix_hi", 8'h0A, db);
		sel(1'b0, 1'b0);
		chk("fix_lo", 8'hBC, db);
		i_smoc_host.wr(smoc_pkg::CONFIG_TWO_ADDR, 8'h10); settle;
		chk("rate_hp", 4'hC, rc);
	endtask
	task automatic t_idle;
		i_smoc_host.wr(smoc_pkg::REST_IDLE_HI_ADDR, 8'h3F); settle;
		i_smoc_host.wr(smoc_pkg::REST_IDLE_LO_ADDR, 8'h21); settle;
		chk("idle", 12'hF21, it);
		i_smoc_host.rd_sel(smoc_pkg::REST_IDLE_HI_ADDR); #1;
		chk("idle_hi_rd", 8'h0F, rd);
		i_smoc_host.rd_sel(smoc_pkg::CONFIG_TWO_ADDR); #1;
		chk("cfg_rd", 8'h10, rd);
	endtask
	initial begin
		repeat (5) @(posedge c);
		r <= 0;
		t_fast;
		t_flex;
		t_order;
		t_idle;
		tally_and_finish;
	end
endmodule // testbench
